// file: pkg/via_defs.vh
`ifndef VIA_DEFS_VH
`define VIA_DEFS_VH

// Register byte offsets on the Avalon-MM slave.
`define VIA_REG_ENABLE   4'h0
`define VIA_REG_PENDING  4'h4
`define VIA_REG_STATUS   4'h8

// Status register field positions.
`define VIA_ST_GLB_EN    0
`define VIA_ST_TRAP_PEND 1
`define VIA_ST_BUSY      2
`define VIA_ST_BOOT      3

// Reset values.
`define VIA_ENABLE_RST   14'h0000
`define VIA_PENDING_RST  14'h0000
`define VIA_GLB_EN_RST   1'b0

// Interrupt source layout.
`define VIA_NUM_SRC      14
`define VIA_NUM_SLOT     16
`define VIA_SLOT_TRAP    4'hF
`define VIA_SLOT_DEFAULT 4'h0

// Common entry point and vector table placement.
`define VIA_ENTRY_ADDR   15'h00FF
`define VIA_TABLE_BASE   8'hE0
`define VIA_BLOCK_LAST   8'hFF

// Acknowledge sequence length in instruction cycles.
`define VIA_ACK_CYCLES   3'd7

`endif

// file: src/via_rank_enc.v
`timescale 1ns/1ns

// Fixed-ranking priority encoder: bit 15 wins over everything, bit 0 loses.
module via_rank_enc (
	input  wire [15:0] active,
	output reg  [3:0]  slot
);

	wire [15:0] above;
	wire [15:0] win;

	assign above[15] = 1'b0;
	assign win[15]   = active[15];

	genvar i;
	generate
		for (i = 0; i < 15; i = i + 1) begin : g_rank
			assign above[i] = above[i+1] | active[i+1];
			assign win[i]   = active[i] & ~above[i];
		end
	endgenerate

	integer k;
	always @* begin
		slot = 4'h0;
		for (k = 0; k < 16; k = k + 1) begin
			if (win[k]) begin
				slot = k[3:0];
			end
		end
	end

endmodule // via_rank_enc

// file: src/via_arbiter.v
// Summary of operation
// - Every acknowledged interrupt loads the program counter with 00FF hex.
// - Software trap ranks highest; default dispatch entry ranks lowest.
// - Each non-trap source has an enable bit and a hardware-set pending flag.
// - Maskable source fires only with enable, global enable, and no trap service.
// - Sample at instruction start; highest rank wins, others stay pending.
// - Reset clears all pending flags, enables and the global enable.
// - Enabling an already pending source triggers an interrupt at once.
// - Mid-instruction events wait for next normal instruction; skips finish first.
// - Acknowledge clears global enable, pushes return address, jumps, seven cycles.
// - Return sets global enable, restores the saved address; pending taken at once.
// - Boot code execution blocks interrupts and leaves global enable unchanged; here a trap instruction is still acknowledged.
// - Dispatch finds highest enabled pending source and jumps through its vector.
// - Table sits at block top; dispatch at block's last byte uses next block.
// - Each vector is fifteen bits from two bytes, high byte first.
// - Slots rise with rank from E0/E1 to trap at FE/FF.
// - With nothing enabled and pending, dispatch uses the lowest vector.
// - Dispatch first cycle makes even low byte E0..FE, keeping PC high byte.
// - Trap pending flag is unmapped; set by trap, cleared by reset or clear instruction. Here it reads as status bit 1.
//
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/1ns
`include "via_defs.vh"

module via_arbiter (
	input  wire        ref_clk,
	input  wire        rst_n,
	input  wire        ce,
	input  wire [3:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	input  wire [13:0] src_cond,
	input  wire        instr_start,
	input  wire        skip_pending,
	input  wire [14:0] pc_next,
	input  wire        trap_instruction,
	input  wire        clear_trap_pending_instruction,
	input  wire        return_from_interrupt_instruction,
	input  wire [14:0] stack_pop_data,
	input  wire        vector_dispatch_instruction,
	input  wire [14:0] dispatch_pc,
	input  wire        in_system_programming,
	input  wire [7:0]  prog_rd_data,
	output wire        int_request,
	output wire        ack_busy,
	output reg         stack_push,
	output reg  [14:0] push_addr,
	output reg         pc_load,
	output reg  [14:0] pc_value,
	output reg         prog_rd,
	output reg  [14:0] prog_rd_addr,
	output reg  [7:0]  dispatch_low_byte
);

	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_ACK  = 5'h02;
	localparam [4:0] ST_VHI  = 5'h04;
	localparam [4:0] ST_VLO  = 5'h08;
	localparam [4:0] ST_VEND = 5'h10;

	////////////////////////////////////////////////////////////////////////////

	reg  [4:0]  state;
	reg  [2:0]  ack_cnt;
	reg  [13:0] enable;
	reg  [13:0] pending;
	reg         global_interrupt_enable;
	reg         trap_pending_flag;
	reg  [13:0] cond_s1;
	reg  [13:0] cond_s2;
	reg  [13:0] cond_s3;
	reg  [6:0]  vec_hi;
	reg  [6:0]  tbl_page;
	reg  [3:0]  vec_slot;
	reg         bus_ack;
	reg  [31:0] next_readdata;

	wire [13:0] cond_rise;
	wire [13:0] active;
	wire [15:0] rank_in;
	wire [3:0]  win_slot;
	wire        bus_req;
	wire        wr_en;
	wire        wr_pend;
	wire        wr_stat;
	wire        maskable_go;
	wire        take_ack;
	wire [7:0]  low_byte;
	wire [6:0]  page_sel;

	////////////////////////////////////////////////////////////////////////////
	// Source conditions arrive asynchronously, so they are synchronised and
	// only a rising edge sets a pending flag; a held condition sets it once.

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			cond_s1 <= 14'h0000;
			cond_s2 <= 14'h0000;
			cond_s3 <= 14'h0000;
		end else if (ce) begin
			cond_s1 <= src_cond;
			cond_s2 <= cond_s1;
			cond_s3 <= cond_s2;
		end
	end

	assign cond_rise = cond_s2 & ~cond_s3;

	////////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: every access is answered one cycle after it is seen.

	assign bus_req         = avs_read | avs_write;
	assign avs_waitrequest = bus_req & ~bus_ack;
	assign wr_en           = avs_write & bus_ack & (avs_address == `VIA_REG_ENABLE);
	assign wr_pend         = avs_write & bus_ack & (avs_address == `VIA_REG_PENDING);
	assign wr_stat         = avs_write & bus_ack & (avs_address == `VIA_REG_STATUS);

	always @* begin
		next_readdata = 32'h00000000;
		case (avs_address)
			`VIA_REG_ENABLE: begin
				next_readdata[13:0] = enable;
			end
			`VIA_REG_PENDING: begin
				next_readdata[13:0] = pending;
			end
			`VIA_REG_STATUS: begin
				next_readdata[`VIA_ST_GLB_EN]    = global_interrupt_enable;
				// The trap flag is visible for debug only; it cannot be written.
				next_readdata[`VIA_ST_TRAP_PEND] = trap_pending_flag;
				next_readdata[`VIA_ST_BUSY]      = ack_busy;
				next_readdata[`VIA_ST_BOOT]      = in_system_programming;
			end
			default: begin
				next_readdata = 32'h00000000;
			end
		endcase
	end

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			bus_ack      <= 1'b0;
			avs_readdata <= 32'h00000000;
		end else if (ce) begin
			bus_ack <= bus_req & ~bus_ack;
			if (avs_read & ~bus_ack) begin
				avs_readdata <= next_readdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Enable and pending bits. A hardware set wins over a software clear in the
	// same cycle so that no event is lost.

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			enable  <= `VIA_ENABLE_RST;
			pending <= `VIA_PENDING_RST;
		end else if (ce) begin
			if (wr_en) begin
				enable <= avs_writedata[13:0];
			end
			if (wr_pend) begin
				pending <= avs_writedata[13:0] | cond_rise;
			end else begin
				pending <= pending | cond_rise;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Arbitration. Slot 15 is the trap, slot 0 the default entry, and the
	// maskable sources fill slots 1 to 14 in rising rank.

	assign active = enable & pending;

	// The default slot is always asserted so an empty dispatch resolves to it.
	assign rank_in = {trap_pending_flag, active, 1'b1};

	via_rank_enc u_rank (
		.active (rank_in),
		.slot   (win_slot)
	);

	// Enabling a source whose flag is already set qualifies it at once.
	assign maskable_go = (|active) & global_interrupt_enable & ~trap_pending_flag;

	// Skipped instructions are not normally executed, so sampling waits.
	assign take_ack = instr_start & ~skip_pending & ~in_system_programming &
		maskable_go & (state == ST_IDLE);

	assign int_request = maskable_go & ~in_system_programming;
	assign ack_busy    = (state != ST_IDLE);

	assign low_byte = `VIA_TABLE_BASE + {3'b000, win_slot, 1'b0};

	// A dispatch at the last byte of a block reads the next block's table.
	assign page_sel = (dispatch_pc[7:0] == `VIA_BLOCK_LAST) ?
		(dispatch_pc[14:8] + 7'h01) : dispatch_pc[14:8];

	////////////////////////////////////////////////////////////////////////////
	// Trap flag and global enable.

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			trap_pending_flag <= 1'b0;
		end else if (ce) begin
			if (trap_instruction & (state == ST_IDLE)) begin
				trap_pending_flag <= 1'b1;
			end else if (clear_trap_pending_instruction) begin
				trap_pending_flag <= 1'b0;
			end
		end
	end

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			global_interrupt_enable <= `VIA_GLB_EN_RST;
		end else if (ce) begin
			if ((state == ST_ACK) && (ack_cnt == 3'd1)) begin
				global_interrupt_enable <= 1'b0;
			end else if (return_from_interrupt_instruction & (state == ST_IDLE)) begin
				global_interrupt_enable <= 1'b1;
			end else if (wr_stat) begin
				// Boot code leaves this bit alone; only software, acknowledge or return change it.
				global_interrupt_enable <= avs_writedata[`VIA_ST_GLB_EN];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer: acknowledge (seven cycles) and vector dispatch (table walk).
	// The core holds its own sequencer while ack_busy is high.

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			state             <= ST_IDLE;
			ack_cnt           <= 3'd0;
			stack_push        <= 1'b0;
			push_addr         <= 15'h0000;
			pc_load           <= 1'b0;
			pc_value          <= 15'h0000;
			prog_rd           <= 1'b0;
			prog_rd_addr      <= 15'h0000;
			dispatch_low_byte <= 8'h00;
			vec_hi            <= 7'h00;
			tbl_page          <= 7'h00;
			vec_slot          <= 4'h0;
		end else if (ce) begin
			stack_push <= 1'b0;
			pc_load    <= 1'b0;
			prog_rd    <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (trap_instruction | take_ack) begin
						// The trap is non-maskable and needs no instruction start.
						state      <= ST_ACK;
						ack_cnt    <= 3'd1;
						stack_push <= 1'b1;
						push_addr  <= pc_next;
					end else if (return_from_interrupt_instruction) begin
						pc_load  <= 1'b1;
						pc_value <= stack_pop_data;
					end else if (vector_dispatch_instruction) begin
						dispatch_low_byte <= low_byte;
						vec_slot          <= win_slot;
						tbl_page          <= page_sel;
						pc_load           <= 1'b1;
						pc_value          <= {dispatch_pc[14:8], low_byte};
						prog_rd           <= 1'b1;
						prog_rd_addr      <= {page_sel, low_byte};
						state             <= ST_VHI;
					end
				end
				ST_ACK: begin
					if (ack_cnt == `VIA_ACK_CYCLES) begin
						ack_cnt <= 3'd0;
						state   <= ST_IDLE;
					end else begin
						ack_cnt <= ack_cnt + 3'd1;
					end
					// The jump lands in the last of the seven busy cycles.
					if (ack_cnt == (`VIA_ACK_CYCLES - 3'd1)) begin
						pc_load  <= 1'b1;
						pc_value <= `VIA_ENTRY_ADDR;
					end
				end
				ST_VHI: begin
					// Program memory answers one cycle after the read strobe, so the
					// high byte is not here yet; the low byte is requested meanwhile.
					prog_rd      <= 1'b1;
					prog_rd_addr <= {tbl_page, dispatch_low_byte | 8'h01};
					state        <= ST_VLO;
				end
				ST_VLO: begin
					vec_hi <= prog_rd_data[6:0];
					state  <= ST_VEND;
				end
				ST_VEND: begin
					pc_load  <= 1'b1;
					pc_value <= {vec_hi, prog_rd_data};
					state    <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

endmodule // via_arbiter

// file: tb/via_arbiter_properties.sv
`timescale 1ns/1ns
module via_arbiter_properties (
	input wire		ref_clk,
	input wire		rst_n,
	input wire		instr_start,
	input wire		skip_pending,
	input wire	[14:0]	pc_next,
	input wire		trap_instruction,
	input wire		return_from_interrupt_instruction,
	input wire	[14:0]	stack_pop_data,
	input wire		vector_dispatch_instruction,
	input wire	[14:0]	dispatch_pc,
	input wire		in_system_programming,
	input wire	[7:0]	prog_rd_data,
	input wire		int_request,
	input wire		ack_busy,
	input wire		stack_push,
	input wire	[14:0]	push_addr,
	input wire		pc_load,
	input wire	[14:0]	pc_value,
	input wire		prog_rd,
	input wire	[14:0]	prog_rd_addr,
	input wire	[7:0]	dispatch_low_byte
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire idle_go = !ack_busy && !trap_instruction;
	wire ack_go  = instr_start && int_request && !skip_pending
		&& !in_system_programming && idle_go;
	wire disp_go = vector_dispatch_instruction && !instr_start && idle_go;
	sequence first_read_s;
		prog_rd && prog_rd_addr[7:0] == dispatch_low_byte
		&& prog_rd_addr[14:8] == $past(dispatch_pc[14:8]) + ($past(dispatch_pc[7:0]) == 8'hFF);
	endsequence
	sequence hi_lo_s;
		prog_rd && prog_rd_addr[0]
		##2 pc_load && pc_value == {$past(prog_rd_data[6:0], 2), $past(prog_rd_data)};
	endsequence
	ack_push_a: assert property (ack_go |=> stack_push && push_addr == $past(pc_next))
		else $error("no push after ack");
	entry_jump_a: assert property (ack_go |-> ##7 pc_load && pc_value == 15'h00FF)
		else $error("no jump to entry");
	busy_span_a: assert property (ack_go |=> ack_busy [*7] ##1 !ack_busy)
		else $error("ack length wrong");
	skip_hold_a: assert property (instr_start && skip_pending && idle_go |=> !stack_push)
		else $error("ack on skipped instruction");
	boot_hold_a: assert property (instr_start && in_system_programming && idle_go
		|=> !stack_push) else $error("ack in boot code");
	trap_take_a: assert property (trap_instruction && !ack_busy |=> stack_push)
		else $error("trap not taken");
	disp_low_a: assert property (disp_go |=> pc_load && pc_value[7:0] == dispatch_low_byte
		&& pc_value[14:8] == $past(dispatch_pc[14:8]) && dispatch_low_byte >= 8'hE0
		&& !dispatch_low_byte[0]) else $error("bad dispatch low byte");
	table_walk_a: assert property (disp_go |=> first_read_s ##1 hi_lo_s)
		else $error("bad vector fetch");
	return_load_a: assert property (return_from_interrupt_instruction
		&& !instr_start && idle_go
		|=> pc_load && pc_value == $past(stack_pop_data)) else $error("bad return");
endmodule // via_arbiter_properties

// file: tb/via_core_model.sv
`timescale 1ns/1ns
module via_core_model (
	input wire		ref_clk,
	input wire		prog_rd,
	input wire	[14:0]	prog_rd_addr,
	output logic	[7:0]	prog_rd_data
);
	initial prog_rd_data = 8'hA5;
	// Even bytes carry bit 7 set, so a target that keeps it is caught.
	// Between reads the bus toggles instead of holding stale data.
	always @(posedge ref_clk) begin
		if (prog_rd)
			prog_rd_data <= prog_rd_addr[0] ? prog_rd_addr[7:0] ^ 8'h5A : {1'b1, prog_rd_addr[6:0]};
		else
			prog_rd_data <= ~prog_rd_data;
	end
endmodule // via_core_model

// file: tb/via_arbiter_tb.sv
`timescale 1ns/1ns
module via_arbiter_tb;
	logic		ref_clk, rst_n, avs_read, avs_write, skip_pending, in_system_programming;
	logic	[3:0]	avs_address;
	logic	[31:0]	avs_writedata, q;
	logic	[13:0]	src_cond;
	logic	[14:0]	pc_next, stack_pop_data, dispatch_pc, last_pc, last_push;
	logic	[4:0]	pulse_v;
	wire	[31:0]	avs_readdata;
	wire	[14:0]	push_addr, pc_value, prog_rd_addr;
	wire	[7:0]	prog_rd_data, dispatch_low_byte;
	wire		avs_waitrequest, int_request, ack_busy, stack_push, pc_load, prog_rd;
	integer		miscompares = 0, checks = 0;
	via_arbiter dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .src_cond(src_cond),
		.instr_start(pulse_v[0]), .skip_pending(skip_pending), .pc_next(pc_next),
		.trap_instruction(pulse_v[1]), .clear_trap_pending_instruction(pulse_v[2]),
		.return_from_interrupt_instruction(pulse_v[3]), .stack_pop_data(stack_pop_data),
		.vector_dispatch_instruction(pulse_v[4]), .dispatch_pc(dispatch_pc),
		.in_system_programming(in_system_programming), .prog_rd_data(prog_rd_data),
		.int_request(int_request), .ack_busy(ack_busy), .stack_push(stack_push),
		.push_addr(push_addr), .pc_load(pc_load), .pc_value(pc_value), .prog_rd(prog_rd),
		.prog_rd_addr(prog_rd_addr), .dispatch_low_byte(dispatch_low_byte));
	via_core_model core_u (.ref_clk(ref_clk), .prog_rd(prog_rd), .prog_rd_addr(prog_rd_addr),
		.prog_rd_data(prog_rd_data));
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			last_push <= 15'h0000;
			last_pc <= 15'h0000;
		end else begin
			if (stack_push) last_push <= push_addr;
			if (pc_load) last_pc <= pc_value;
		end
	end
	task automatic chk(input [31:0] seen, input [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic bus(input w, input [3:0] a, input [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge ref_clk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic fire(input [4:0] p);
		@(posedge ref_clk);
		pulse_v <= p;
		@(posedge ref_clk);
		pulse_v <= 5'h00;
		repeat (10) @(posedge ref_clk);
	endtask
	function automatic [31:0] tgt(input [7:0] l);
		tgt = {17'h0, l[6:0], (l | 8'h01) ^ 8'h5A};
	endfunction
	task automatic give_verdict;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge ref_clk);
		miscompares++;
		give_verdict;
	end
	initial begin
		{rst_n, avs_read, avs_write, skip_pending, in_system_programming} = 5'h00;
		{avs_address, avs_writedata, src_cond, pulse_v} = 0;
		{pc_next, stack_pop_data, dispatch_pc} = 0;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		bus(0, 4'h0, 0); chk(q, 32'h0);
		bus(0, 4'h4, 0); chk(q, 32'h0);
		bus(0, 4'h8, 0); chk(q, 32'h0);
		bus(0, 4'hC, 0); chk(q, 32'h0);
		$display("test reset done");
		src_cond <= 14'h2001;
		repeat (6) @(posedge ref_clk);
		bus(0, 4'h4, 0); chk(q, 32'h2001);
		bus(1, 4'h8, 32'h1);
		@(posedge ref_clk); chk(int_request, 32'h0);
		bus(1, 4'h0, 32'h2001);
		@(posedge ref_clk); chk(int_request, 32'h1);
		pc_next <= 15'h1234;
		skip_pending <= 1'b1;
		fire(5'h01); chk(last_push, 32'h0);
		skip_pending <= 1'b0;
		fire(5'h01); chk(last_push, 32'h1234);
		chk(last_pc, 32'h00FF);
		bus(0, 4'h8, 0); chk(q, 32'h0);
		bus(0, 4'h4, 0); chk(q, 32'h2001);
		$display("test ack done");
		dispatch_pc <= 15'h00FF;
		fire(5'h10); chk(dispatch_low_byte, 32'hFC);
		chk(last_pc, tgt(8'hFC));
		bus(1, 4'h4, 32'h1);
		bus(1, 4'h8, 32'h1);
		dispatch_pc <= 15'h0234;
		fire(5'h10); chk(dispatch_low_byte, 32'hE2);
		chk(last_pc, tgt(8'hE2));
		$display("test dispatch done");
		bus(1, 4'h8, 32'h0);
		stack_pop_data <= 15'h0456;
		fire(5'h08); chk(last_pc, 32'h0456);
		bus(0, 4'h8, 0); chk(q, 32'h1);
		@(posedge ref_clk); chk(int_request, 32'h1);
		fire(5'h02);
		bus(0, 4'h8, 0); chk(q, 32'h2);
		bus(1, 4'h8, 32'h1);
		@(posedge ref_clk); chk(int_request, 32'h0);
		fire(5'h10); chk(dispatch_low_byte, 32'hFE);
		fire(5'h04);
		bus(0, 4'h8, 0); chk(q, 32'h1);
		$display("test trap done");
		in_system_programming <= 1'b1;
		pc_next <= 15'h0777;
		fire(5'h01); chk(last_push, 32'h1234);
		bus(0, 4'h8, 0); chk(q, 32'h9);
		in_system_programming <= 1'b0;
		fire(5'h01); chk(last_push, 32'h0777);
		bus(1, 4'h4, 32'h0);
		fire(5'h10); chk(dispatch_low_byte, 32'hE0);
		chk(last_pc, tgt(8'hE0));
		$display("test boot and default done");
		give_verdict;
	end
endmodule // via_arbiter_tb
bind via_arbiter via_arbiter_properties chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
	.instr_start(instr_start), .skip_pending(skip_pending), .pc_next(pc_next),
	.trap_instruction(trap_instruction),
	.return_from_interrupt_instruction(return_from_interrupt_instruction),
	.stack_pop_data(stack_pop_data), .vector_dispatch_instruction(vector_dispatch_instruction),
	.dispatch_pc(dispatch_pc), .in_system_programming(in_system_programming),
	.prog_rd_data(prog_rd_data), .int_request(int_request), .ack_busy(ack_busy),
	.stack_push(stack_push), .push_addr(push_addr), .pc_load(pc_load), .pc_value(pc_value),
	.prog_rd(prog_rd), .prog_rd_addr(prog_rd_addr), .dispatch_low_byte(dispatch_low_byte));
